// *** core/gpio_output_override_timers.sv ***
// output override for up to twenty general-purpose pins with per-pin timers
// assumes commands and configuration come from same-clock logic (no synchronisers)
`timescale 1ns/100ps
// Operation
// - command level map bit n sets level of pin n, pins 0..19
// - a 0 bit drives the pin low, a 1 bit drives it high
// - only pins whose mask bit is 1 are touched by a command
// - command changes a pin only if its function is output-low or output-high
// - after reset no pin is configured as an output
// - timer zero holds commanded level until next command, a switch out of output mode, or reset
// - nonzero timer keeps level that many 100 ms ticks, then reverts
// - timer starts only if commanded level differs from configured level
// - timer settings above 6000 are rejected
// - twenty timers: low bank for pins 0..9, high bank for 10..19
// - bits 15..19 exist only in the wide variant
module gpio_output_override_timers #(
	parameter int PINS        = gpio_ovr_pkg::PIN_COUNT,
	parameter bit WIDE_VARIANT = 1'b1,
	parameter int TICK_CYCLES = gpio_ovr_pkg::TICK_CYCLES
) (
	// clock and reset
	input  wire logic                              clk_i,
	input  wire logic                              reset_n_i,
	// output-set command
	input  wire logic                              cmd_valid_i,
	input  wire logic [PINS-1:0]                   cmd_level_i,
	input  wire logic [PINS-1:0]                   output_mask_i,
	// function configuration write
	input  wire logic                              func_we_i,
	input  wire logic [4:0]                        func_sel_i,
	input  wire logic [gpio_ovr_pkg::FUNC_W-1:0]   func_val_i,
	// override timer write, low bank pins 0..9, high bank pins 10..19
	input  wire logic                              timer_we_i,
	input  wire logic                              timer_bank_high_i,
	input  wire logic [3:0]                        timer_idx_i,
	input  wire logic [gpio_ovr_pkg::TIMER_W-1:0]  timer_val_i,
	// status
	output logic                                   timer_reject_o,
	output logic [PINS-1:0]                        override_active_o,
	// pins
	output logic [PINS-1:0]                        gp_pin_o,
	output logic [PINS-1:0]                        gp_pin_oe_n_o
);
	localparam int FW = gpio_ovr_pkg::FUNC_W;
	localparam int TW = gpio_ovr_pkg::TIMER_W;
	localparam int BANK = PINS / 2;

	// pins above the narrow variant simply do not exist there
	function automatic logic pin_present(input int n);
		return WIDE_VARIANT || (n < gpio_ovr_pkg::WIDE_PIN_FIRST);
	endfunction : pin_present

	function automatic logic is_output(input logic [FW-1:0] f);
		return (f == gpio_ovr_pkg::FUNC_OUT_LOW) || (f == gpio_ovr_pkg::FUNC_OUT_HIGH);
	endfunction : is_output

	logic          tick;
	logic [FW-1:0] func_r    [PINS];
	logic [FW-1:0] func_nxt  [PINS];
	logic [TW-1:0] tset_r    [PINS];
	logic [TW-1:0] tset_nxt  [PINS];
	logic [TW-1:0] tcnt_r    [PINS];
	logic [TW-1:0] tcnt_nxt  [PINS];
	logic [PINS-1:0] ovr_r, ovr_nxt, lvl_r, lvl_nxt;
	logic [PINS-1:0] pin_r, pin_nxt, oe_n_r, oe_n_nxt;
	logic          rej_r, rej_nxt;
	logic [4:0]    tsel;

	gpio_tick_div #(
		.DIVIDE (TICK_CYCLES)
	) u_tick (
		.clk_i     (clk_i),
		.reset_n_i (reset_n_i),
		.tick_o    (tick)
	);

	assign tsel = timer_bank_high_i ? 5'(timer_idx_i) + 5'h0A : 5'(timer_idx_i);

	always_comb begin
		rej_nxt = 1'b0;
		for (int n = 0; n < PINS; n++) begin
			logic cfg_lvl;
			logic cmd_hits;
			cfg_lvl = (func_r[n] == gpio_ovr_pkg::FUNC_OUT_HIGH);
			cmd_hits = 1'b0;
			func_nxt[n] = func_r[n];
			tset_nxt[n] = tset_r[n];
			tcnt_nxt[n] = tcnt_r[n];
			ovr_nxt[n] = ovr_r[n];
			lvl_nxt[n] = lvl_r[n];
			if (func_we_i && func_sel_i == 5'(n) && pin_present(n))
				func_nxt[n] = func_val_i;
			if (timer_we_i && tsel == 5'(n) && timer_idx_i < 4'hA && pin_present(n) &&
			    timer_val_i <= gpio_ovr_pkg::TIMER_MAX)
				tset_nxt[n] = timer_val_i;
			// timed overrides count down once per tick, then fall back
			if (ovr_r[n] && tcnt_r[n] != gpio_ovr_pkg::TIMER_ZERO && tick) begin
				tcnt_nxt[n] = tcnt_r[n] - 13'h0001;
				if (tcnt_r[n] == 13'h0001)
					ovr_nxt[n] = 1'b0;
			end
			cmd_hits = cmd_valid_i && output_mask_i[n] && is_output(func_r[n]) &&
			           pin_present(n);
			if (cmd_hits) begin
				lvl_nxt[n] = cmd_level_i[n];
				ovr_nxt[n] = 1'b1;
				// timer only runs when the level departs from the configured one
				tcnt_nxt[n] = (cmd_level_i[n] != cfg_lvl) ? tset_r[n]
				                                          : gpio_ovr_pkg::TIMER_ZERO;
			end
			// leaving output mode drops any override
			if (!is_output(func_nxt[n]))
				ovr_nxt[n] = 1'b0;
			pin_nxt[n] = ovr_nxt[n] ? lvl_nxt[n]
			                        : (func_nxt[n] == gpio_ovr_pkg::FUNC_OUT_HIGH);
			oe_n_nxt[n] = !is_output(func_nxt[n]);
		end
		if (timer_we_i && (timer_val_i > gpio_ovr_pkg::TIMER_MAX || timer_idx_i >= 4'hA))
			rej_nxt = 1'b1;
	end

	always_ff @(posedge clk_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			for (int n = 0; n < PINS; n++) begin
				func_r[n] <= gpio_ovr_pkg::FUNC_DISABLED;
				tset_r[n] <= gpio_ovr_pkg::TIMER_ZERO;
				tcnt_r[n] <= gpio_ovr_pkg::TIMER_ZERO;
			end
			ovr_r <= '0;
			lvl_r <= '0;
			pin_r <= '0;
			oe_n_r <= '1;
			rej_r <= 1'b0;
		end else begin
			for (int n = 0; n < PINS; n++) begin
				func_r[n] <= func_nxt[n];
				tset_r[n] <= tset_nxt[n];
				tcnt_r[n] <= tcnt_nxt[n];
			end
			ovr_r <= ovr_nxt;
			lvl_r <= lvl_nxt;
			pin_r <= pin_nxt;
			oe_n_r <= oe_n_nxt;
			rej_r <= rej_nxt;
		end
	end

	assign gp_pin_o          = pin_r;
	assign gp_pin_oe_n_o     = oe_n_r;
	assign override_active_o = ovr_r;
	assign timer_reject_o    = rej_r;

	// checks on pin 0, representative of all
	sequence s_cmd0_out;
		cmd_valid_i && output_mask_i[0] && is_output(func_r[0]) && !func_we_i;
	endsequence

	chk_cmd_level: assert property (@(posedge clk_i) disable iff (!reset_n_i)
		s_cmd0_out |=> gp_pin_o[0] == $past(cmd_level_i[0]))
		else $error("pin 0 not at commanded level");
	chk_mask_zero: assert property (@(posedge clk_i) disable iff (!reset_n_i)
		(cmd_valid_i && !output_mask_i[0] && !func_we_i && !tick && !timer_we_i) |=>
		$stable(gp_pin_o[0]))
		else $error("masked pin changed");
	chk_nonout_off: assert property (@(posedge clk_i) disable iff (!reset_n_i)
		!is_output(func_r[0]) |-> gp_pin_oe_n_o[0] && !override_active_o[0])
		else $error("non-output pin driven");
	chk_reset_idle: assert property (@(posedge clk_i)
		$rose(reset_n_i) |-> gp_pin_oe_n_o == '1)
		else $error("pin driven after reset");
	chk_hold_zero: assert property (@(posedge clk_i) disable iff (!reset_n_i)
		(override_active_o[0] && tcnt_r[0] == gpio_ovr_pkg::TIMER_ZERO && !func_we_i) |=>
		override_active_o[0])
		else $error("untimed override ended");
	chk_time_out: assert property (@(posedge clk_i) disable iff (!reset_n_i)
		(override_active_o[0] && tcnt_r[0] == 13'h0001 && tick && !cmd_valid_i) |=>
		!override_active_o[0] && gp_pin_o[0] == (func_r[0] == gpio_ovr_pkg::FUNC_OUT_HIGH))
		else $error("timed override did not revert");
	chk_same_lvl: assert property (@(posedge clk_i) disable iff (!reset_n_i)
		(s_cmd0_out and (cmd_level_i[0] == (func_r[0] == gpio_ovr_pkg::FUNC_OUT_HIGH)))
		|=> tcnt_r[0] == gpio_ovr_pkg::TIMER_ZERO)
		else $error("timer started without level change");
	chk_reject_big: assert property (@(posedge clk_i) disable iff (!reset_n_i)
		(timer_we_i && timer_val_i > gpio_ovr_pkg::TIMER_MAX) |=> timer_reject_o ##0
		tset_r[0] == $past(tset_r[0]))
		else $error("oversized timer accepted");
	chk_tick_step: assert property (@(posedge clk_i) disable iff (!reset_n_i)
		(override_active_o[0] && tcnt_r[0] > 13'h0001 && tick && !cmd_valid_i) |=>
		tcnt_r[0] == $past(tcnt_r[0]) - 13'h0001)
		else $error("timer did not decrement");

	// pin 0 timed run: a level that departs from the configured one arms the timer
	sequence s_timed0_start;
		s_cmd0_out ##0 (cmd_level_i[0] != (func_r[0] == gpio_ovr_pkg::FUNC_OUT_HIGH)) ##0
		(tset_r[0] != gpio_ovr_pkg::TIMER_ZERO);
	endsequence

	sequence s_timed0_armed;
		override_active_o[0] ##0 (tcnt_r[0] != gpio_ovr_pkg::TIMER_ZERO);
	endsequence

	sequence s_func0_write;
		func_we_i && func_sel_i == 5'h00;
	endsequence

	sequence s_low0_write;
		timer_we_i && !timer_bank_high_i && timer_idx_i == 4'h0 &&
		timer_val_i <= gpio_ovr_pkg::TIMER_MAX;
	endsequence

	sequence s_high0_write;
		timer_we_i && timer_bank_high_i && timer_idx_i == 4'h0 &&
		timer_val_i <= gpio_ovr_pkg::TIMER_MAX;
	endsequence

	// the count loads from the setting held before any write in the same cycle
	chk_timer_start: assert property (@(posedge clk_i) disable iff (!reset_n_i)
		s_timed0_start |=> s_timed0_armed ##0 tcnt_r[0] == $past(tset_r[0]))
		else $error("timed override not armed");

	chk_hold_level: assert property (@(posedge clk_i) disable iff (!reset_n_i)
		(override_active_o[0] && tcnt_r[0] == gpio_ovr_pkg::TIMER_ZERO && !cmd_valid_i &&
		!func_we_i) |=> $stable(gp_pin_o[0]))
		else $error("untimed override level moved");

	// function writes decide the pin enable one cycle later
	chk_oe_on: assert property (@(posedge clk_i) disable iff (!reset_n_i)
		(s_func0_write ##0 is_output(func_val_i)) |=> !gp_pin_oe_n_o[0])
		else $error("output function left pin undriven");

	chk_oe_off: assert property (@(posedge clk_i) disable iff (!reset_n_i)
		(s_func0_write ##0 !is_output(func_val_i)) |=>
		gp_pin_oe_n_o[0] && !override_active_o[0])
		else $error("non-output function left pin driven");

	// without an override the pin shows the level its function configures
	chk_cfg_level: assert property (@(posedge clk_i) disable iff (!reset_n_i)
		(is_output(func_r[0]) && !override_active_o[0]) |->
		gp_pin_o[0] == (func_r[0] == gpio_ovr_pkg::FUNC_OUT_HIGH))
		else $error("pin not at configured level");

	// an undriven pin keeps its data bit low so enabling it later starts clean
	chk_idle_low: assert property (@(posedge clk_i) disable iff (!reset_n_i)
		!is_output(func_r[0]) |-> !gp_pin_o[0])
		else $error("undriven pin shows high");

	chk_reset_quiet: assert property (@(posedge clk_i)
		$rose(reset_n_i) |-> override_active_o == '0 && gp_pin_o == '0 && !timer_reject_o)
		else $error("state left over after reset");

	// settings within the limit for an index below 10 of a present pin are stored; others leave the stored value alone
	chk_low_load: assert property (@(posedge clk_i) disable iff (!reset_n_i)
		s_low0_write |=> tset_r[0] == $past(timer_val_i))
		else $error("valid timer setting not stored");

	chk_high_load: assert property (@(posedge clk_i) disable iff (!reset_n_i)
		s_high0_write |=> tset_r[BANK] == $past(timer_val_i))
		else $error("high bank setting not stored");

	chk_reject_idx: assert property (@(posedge clk_i) disable iff (!reset_n_i)
		(timer_we_i && timer_idx_i >= 4'hA) |=> timer_reject_o)
		else $error("out-of-bank timer index accepted");

	chk_accept_ok: assert property (@(posedge clk_i) disable iff (!reset_n_i)
		(timer_we_i && timer_val_i <= gpio_ovr_pkg::TIMER_MAX && timer_idx_i < 4'hA) |=>
		!timer_reject_o)
		else $error("valid timer setting rejected");

	chk_reject_quiet: assert property (@(posedge clk_i) disable iff (!reset_n_i)
		!timer_we_i |=> !timer_reject_o)
		else $error("reject pulse without a timer write");

	// between ticks a running timer must not move
	chk_tick_idle: assert property (@(posedge clk_i) disable iff (!reset_n_i)
		(override_active_o[0] && !tick && !cmd_valid_i && !func_we_i) |=>
		$stable(tcnt_r[0]))
		else $error("timer moved between ticks");

	chk_tick_pulse: assert property (@(posedge clk_i) disable iff (!reset_n_i)
		(TICK_CYCLES > 1 && tick) |=> !tick)
		else $error("tick wider than one cycle");

	// mapping and mask checks run on every present pin; absent pins must stay undriven
	for (genvar g = 0; g < PINS; g++) begin : g_pin_chk
		sequence s_cmd_hit;
			cmd_valid_i && output_mask_i[g] && is_output(func_r[g]) && !func_we_i;
		endsequence

		if (pin_present(g)) begin : g_present
			chk_pin_level: assert property (@(posedge clk_i) disable iff (!reset_n_i)
				s_cmd_hit |=> gp_pin_o[g] == $past(cmd_level_i[g]))
				else $error("pin not at its commanded level");
			chk_pin_mask: assert property (@(posedge clk_i) disable iff (!reset_n_i)
				(cmd_valid_i && !output_mask_i[g] && !func_we_i && !tick) |=>
				$stable(gp_pin_o[g]) && $stable(override_active_o[g]))
				else $error("masked pin changed by command");
		end else begin : g_absent
			chk_pin_absent: assert property (@(posedge clk_i) disable iff (!reset_n_i)
				gp_pin_oe_n_o[g] && !override_active_o[g])
				else $error("absent pin driven");
		end
	end
endmodule : gpio_output_override_timers

// *** core/gpio_tick_div.sv ***
// prescaler producing a one-cycle enable pulse every DIVIDE clocks
// assumes clk_i is the system clock; no other domain involved
`timescale 1ns/100ps
module gpio_tick_div #(
	parameter int DIVIDE = gpio_ovr_pkg::TICK_CYCLES
) (
	// clock and reset
	input  wire logic clk_i,
	input  wire logic reset_n_i,
	// tick out
	output logic      tick_o
);
	logic [31:0] count_r;
	logic [31:0] count_nxt;
	logic        tick_r;
	logic        tick_nxt;

	always_comb begin
		tick_nxt = 1'b0;
		count_nxt = count_r + 32'h0000_0001;
		if (count_r == 32'(DIVIDE - 1)) begin
			count_nxt = 32'h0000_0000;
			tick_nxt = 1'b1;
		end
	end

	always_ff @(posedge clk_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			count_r <= 32'h0000_0000;
			tick_r <= 1'b0;
		end else begin
			count_r <= count_nxt;
			tick_r <= tick_nxt;
		end
	end

	assign tick_o = tick_r;
endmodule : gpio_tick_div

// *** inc/gpio_ovr_pkg.sv ***
// constants for the output override block: function codes, widths, timing
// assumes a single 100 MHz system clock
package gpio_ovr_pkg;
	localparam int          PIN_COUNT      = 20;
	localparam int          FUNC_W         = 3;
	localparam int          TIMER_W        = 13;
	localparam logic [2:0]  FUNC_DISABLED  = 3'h0;
	localparam logic [2:0]  FUNC_OUT_LOW   = 3'h4;
	localparam logic [2:0]  FUNC_OUT_HIGH  = 3'h5;
	localparam logic [12:0] TIMER_MAX      = 13'h1770;
	localparam logic [12:0] TIMER_ZERO     = 13'h0000;
	localparam int          CLK_PERIOD_NS  = 10;
	localparam int          TICK_PERIOD_MS = 100;
	localparam int          TICK_CYCLES    = TICK_PERIOD_MS * 1000000 / CLK_PERIOD_NS;
	localparam int          WIDE_PIN_FIRST = 15;
endpackage : gpio_ovr_pkg

// *** test/ovr_host_model.sv ***
// host model: issues function, timer and output-set writes as one-cycle strobes
// assumes the bench clock; strobes change on the falling edge
`timescale 1ns/100ps
module ovr_host_model (
	input  wire logic clk_i,
	output logic      cmd_v_o,
	output logic [19:0] lvl_o,
	output logic [19:0] msk_o,
	output logic      fwe_o,
	output logic [4:0]  fsel_o,
	output logic [2:0]  fval_o,
	output logic      twe_o,
	output logic      thi_o,
	output logic [3:0]  tidx_o,
	output logic [12:0] tval_o
);
	// data lines show the inverse once a strobe drops, so stale values never look valid
	initial {cmd_v_o, lvl_o, msk_o, fwe_o, fsel_o, fval_o, twe_o, thi_o, tidx_o, tval_o} = '0;
	task automatic func(input logic [4:0] s, input logic [2:0] v);
		@(negedge clk_i);
		{fsel_o, fval_o, fwe_o} = {s, v, 1'b1};
		@(negedge clk_i);
		{fsel_o, fval_o, fwe_o} = {~s, ~v, 1'b0};
	endtask : func
	task automatic timer(input logic h, input logic [3:0] i, input logic [12:0] v);
		@(negedge clk_i);
		{thi_o, tidx_o, tval_o, twe_o} = {h, i, v, 1'b1};
		@(negedge clk_i);
		{thi_o, tidx_o, tval_o, twe_o} = {~h, ~i, ~v, 1'b0};
	endtask : timer
	task automatic cmd(input logic [19:0] l, input logic [19:0] m);
		@(negedge clk_i);
		{lvl_o, msk_o, cmd_v_o} = {l, m, 1'b1};
		@(negedge clk_i);
		{lvl_o, msk_o, cmd_v_o} = {~l, ~m, 1'b0};
	endtask : cmd
endmodule : ovr_host_model

// *** test/tb_top.sv ***
// bench for the output override block, host model drives all requests
// assumes a 10-cycle tick prescaler so timer runs stay short
`timescale 1ns/100ps
module tb_top;
	logic        clk_i, reset_n_i, cv, fwe, twe, thi, rej;
	logic [19:0] lvl, msk, ov, pin, oen;
	logic [4:0]  fsel;
	logic [2:0]  fval;
	logic [3:0]  tidx;
	logic [12:0] tval;
	int          fail_count, check_count, rej_n, n;
	gpio_output_override_timers #(.TICK_CYCLES(10)) gpio_output_override_timers_inst (
		.clk_i(clk_i), .reset_n_i(reset_n_i), .cmd_valid_i(cv), .cmd_level_i(lvl),
		.output_mask_i(msk), .func_we_i(fwe), .func_sel_i(fsel), .func_val_i(fval),
		.timer_we_i(twe), .timer_bank_high_i(thi), .timer_idx_i(tidx), .timer_val_i(tval),
		.timer_reject_o(rej), .override_active_o(ov), .gp_pin_o(pin), .gp_pin_oe_n_o(oen));
	ovr_host_model ovr_host_model_inst (.clk_i(clk_i), .cmd_v_o(cv), .lvl_o(lvl),
		.msk_o(msk), .fwe_o(fwe), .fsel_o(fsel), .fval_o(fval), .twe_o(twe),
		.thi_o(thi), .tidx_o(tidx), .tval_o(tval));
	initial begin
		clk_i = 1'b0;
		forever #5 clk_i = ~clk_i;
	end
	always @(negedge clk_i) if (rej === 1'b1) rej_n++;
	task automatic check(input string nm, input logic [19:0] seen, input logic [19:0] exp);
		check_count++;
		if (seen !== exp) begin
			fail_count++;
			$display("BAD %s expected %h seen %h", nm, exp, seen);
		end
	endtask : check
	task automatic wait_drop(input int b);
		n = 0;
		while (ov[b] !== 1'b0 && n < 40) begin
			@(negedge clk_i);
			n++;
		end
		if (ov[b] !== 1'b0) begin
			check("ovr wait", 20'h0_0001, 20'h0_0000);
			complete_run;
		end
	endtask : wait_drop
	task automatic complete_run;
		$display("checks %0d mismatches %0d", check_count, fail_count);
		if (fail_count == 0 && check_count > 0)
			$display("Simulation passed");
		else
			$display("Simulation failed");
		$finish;
	endtask : complete_run
	task automatic t_reset;
		check("oe_n", oen, 20'hF_FFFF);
		check("pin", pin, 20'h0_0000);
		$display("done reset");
	endtask : t_reset
	task automatic t_levels;
		ovr_host_model_inst.func(5'd0, gpio_ovr_pkg::FUNC_OUT_HIGH);
		ovr_host_model_inst.func(5'd1, gpio_ovr_pkg::FUNC_OUT_LOW);
		ovr_host_model_inst.func(5'd19, gpio_ovr_pkg::FUNC_OUT_HIGH);
		check("oe_n", oen, 20'h7_FFFC);
		// pin 2 is not an output, pin 19 is masked off
		ovr_host_model_inst.cmd(20'h0_0006, 20'h0_0007);
		check("pin", pin, 20'h8_0002);
		ovr_host_model_inst.cmd(20'h0_0000, 20'h8_0000);
		repeat (50) @(negedge clk_i);
		check("pin hold", pin, 20'h0_0002);
		check("oe_n", oen, 20'h7_FFFC);
		$display("done levels");
	endtask : t_levels
	task automatic t_timer;
		ovr_host_model_inst.func(5'd3, gpio_ovr_pkg::FUNC_OUT_HIGH);
		ovr_host_model_inst.func(5'd12, gpio_ovr_pkg::FUNC_OUT_LOW);
		ovr_host_model_inst.timer(1'b0, 4'd3, 13'h0003);
		ovr_host_model_inst.timer(1'b1, 4'd2, 13'h0003);
		ovr_host_model_inst.cmd(20'h0_1000, 20'h0_1008);
		check("ovr", ov & 20'h0_1008, 20'h0_1008);
		repeat (15) @(negedge clk_i);
		check("pin held", pin & 20'h0_1008, 20'h0_1000);
		wait_drop(12);
		// one shared tick: both banks must drop in the same cycle
		check("ovr end", ov & 20'h0_1008, 20'h0_0000);
		check("pin end", pin & 20'h0_1008, 20'h0_0008);
		$display("done timer");
	endtask : t_timer
	task automatic t_same;
		ovr_host_model_inst.timer(1'b0, 4'd0, 13'h0002);
		// pin 0 is configured high, so a high command must not arm its timer
		ovr_host_model_inst.cmd(20'h0_0001, 20'h0_0001);
		repeat (40) @(negedge clk_i);
		check("ovr same", ov & 20'h0_0001, 20'h0_0001);
		check("pin same", pin & 20'h0_0001, 20'h0_0001);
		ovr_host_model_inst.cmd(20'h0_0000, 20'h0_0001);
		check("pin low", pin & 20'h0_0001, 20'h0_0000);
		wait_drop(0);
		// two ticks of a free-running 10-cycle prescaler: 11 to 20 cycles
		check("span", 20'(n >= 11 && n <= 20), 20'h0_0001);
		check("pin back", pin & 20'h0_0001, 20'h0_0001);
		$display("done same");
	endtask : t_same
	task automatic t_reject;
		n = rej_n;
		ovr_host_model_inst.timer(1'b0, 4'd0, 13'h1771);
		repeat (2) @(negedge clk_i);
		check("reject", 20'(rej_n - n), 20'h0_0001);
		ovr_host_model_inst.timer(1'b1, 4'd9, 13'h1770);
		repeat (2) @(negedge clk_i);
		check("accept", 20'(rej_n - n), 20'h0_0001);
		ovr_host_model_inst.timer(1'b0, 4'hA, 13'h0001);
		repeat (2) @(negedge clk_i);
		check("reject idx", 20'(rej_n - n), 20'h0_0002);
		$display("done reject");
	endtask : t_reject
	task automatic t_midreset;
		check("ovr pre", ov & 20'h0_0002, 20'h0_0002);
		@(negedge clk_i);
		reset_n_i = 1'b0;
		repeat (3) @(negedge clk_i);
		reset_n_i = 1'b1;
		check("ovr rst", ov, 20'h0_0000);
		repeat (2) @(negedge clk_i);
		check("oe_n rst", oen, 20'hF_FFFF);
		check("pin rst", pin, 20'h0_0000);
		$display("done midreset");
	endtask : t_midreset
	initial begin
		reset_n_i = 1'b0;
		repeat (16) @(posedge clk_i);
		@(negedge clk_i);
		reset_n_i = 1'b1;
		t_reset;
		t_levels;
		t_timer;
		t_same;
		t_reject;
		t_midreset;
		complete_run;
	end
endmodule : tb_top
